// ### hdl/encx_check_if.sv
// carrier between the sequencer and its target checker
interface encx_check_if;
  import encx_pkg::*;
  logic longModeActive;
  logic csLongBit;
  logic inEnclave;
  logic [ADDR_W-1:0] target;
  logic [LIM_W-1:0] csLimit;
  logic pfPending;
  encx_verdict_t verdict;
  logic mode64;
  modport seq (output longModeActive, csLongBit, inEnclave, target, csLimit, pfPending,
    input verdict, mode64);
  modport chk (input longModeActive, csLongBit, inEnclave, target, csLimit, pfPending,
    output verdict, mode64);
endinterface

// ### hdl/encx_exit_sequencer.sv
// enclave exit leaf micro-sequence
//
// How it works
// - leaf selector value 4 starts the exit; valid in 32 and 64-bit modes
// - success loads instruction pointer from target, count register gets async exit pointer
// - 64-bit when long mode and code long bit; check canonical else limit
// - target inside enclave still completes; fetch is then non-enclave
// - both auxiliary data segments restored from entry copies
// - extended feature register restored when os extended save enable set
// - code breakpoints outside the enclave range always unsuppressed
// - opted-out: unsuppress breakpoints, trap flag, monitor trap, branch record, counters
// - trap flag set after restore pends single-step debug exception
// - monitor trap control set pends monitor trap exit
// - capability bit 6 and shadow stack enabled: store pointer to previous field
// - restore flow config when branch tracking or shadow stacks supported, shadow pointer when shadow stacks supported
// - protection and branch tracking on: await branch target, suppress cleared
// - finally clear enclave flag, mark structure inactive, flush linear context
// - exit outside enclave mode raises general protection fault code 0
// - faulting memory operand access raises page fault
// - no concurrency restriction against other leaves
// - current instruction pointer captured for the branch record
// - restored state comes from save registers written at entry
module encx_exit_sequencer
  import encx_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  // instruction issue
  input wire logic issueValid,
  input wire logic [31:0] leafSelector,
  input wire logic [ADDR_W-1:0] targetAddr,
  input wire logic [ADDR_W-1:0] currentInstrPtr,
  input wire logic pageFaultIn,
  input wire logic [15:0] pageFaultCode,
  // mode state
  input wire logic longModeActive,
  input wire logic csLongBit,
  input wire logic [LIM_W-1:0] csLimit,
  input wire logic osExtSaveEnable,
  input wire logic flowProtectEnable,
  input wire logic capPrevShadow,
  input wire logic supportBranchTrack,
  input wire logic supportShadowStack,
  input wire logic monitorTrapCtl,
  input wire logic [ADDR_W-1:0] asyncExitPointer,
  input wire logic [ADDR_W-1:0] shadowStackPtrIn,
  input wire logic [CFG_W-1:0] userFlowConfigIn,
  // entry save
  input wire logic entrySave,
  input wire logic entryDebugOptin,
  input wire logic [XCR_W-1:0] extFeatureIn,
  input wire logic trapFlagIn,
  input encx_seg_t segAIn,
  input encx_seg_t segBIn,
  // results
  output logic done,
  output logic faultValid,
  output logic [7:0] faultVector,
  output logic [15:0] faultCode,
  output logic [ADDR_W-1:0] instrPtr,
  output logic [ADDR_W-1:0] countReg,
  output logic [ADDR_W-1:0] lastBranchFrom,
  output encx_seg_t segA,
  output encx_seg_t segB,
  output logic [XCR_W-1:0] extFeatureEnableReg,
  output logic trapFlag,
  output logic inEnclaveFlag,
  output logic [1:0] tcsState,
  output logic [ADDR_W-1:0] prevShadowPtr,
  output logic prevShadowWrite,
  output logic [CFG_W-1:0] userFlowConfig,
  output logic [ADDR_W-1:0] shadowStackPtr,
  output logic outsideBpSuppressed,
  output logic insideBpSuppressed,
  output logic monitorTrapSuppressed,
  output logic branchRecordSuppressed,
  output logic perfMonSuppressed,
  output logic anyThreadDemoted,
  output logic pendSingleStep,
  output logic pendMonitorTrap,
  output logic flushLinear,
  output logic nonEnclaveFetch
);
  typedef enum logic [1:0] {
    ENCX_IDLE,
    ENCX_CHECK,
    ENCX_COMMIT,
    ENCX_FINISH
  } encx_state_t;

  encx_state_t state_q;
  logic [ADDR_W-1:0] tgt_q;
  logic [XCR_W-1:0] saveXcr_q;
  logic saveTf_q;
  logic optin_q;
  logic [CFG_W-1:0] saveCfg_q;
  logic [ADDR_W-1:0] saveSsp_q;
  encx_seg_t saveA_q;
  encx_seg_t saveB_q;
  logic restoreLoad;
  logic [CFG_W-1:0] cfgRestored;
  logic startExit;

  encx_check_if chkBus();

  assign chkBus.longModeActive = longModeActive;
  assign chkBus.csLongBit = csLongBit;
  assign chkBus.inEnclave = inEnclaveFlag;
  assign chkBus.target = tgt_q;
  assign chkBus.csLimit = csLimit;
  assign chkBus.pfPending = pageFaultIn;

  encx_target_check u_check (
    .chk(chkBus)
  );

  // =============================================
  // sequence control
  // =============================================
  assign startExit = issueValid && (leafSelector == LEAF_EXIT);
  assign restoreLoad = (state_q == ENCX_CHECK) && (chkBus.verdict == ENCX_OK);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ENCX_IDLE;
      tgt_q <= ADDR_ZERO;
    end else begin
      unique case (state_q)
        ENCX_IDLE: begin
          if (startExit) begin
            tgt_q <= targetAddr;
            state_q <= ENCX_CHECK;
          end
        end
        ENCX_CHECK: state_q <= restoreLoad ? ENCX_COMMIT : ENCX_IDLE;
        ENCX_COMMIT: state_q <= ENCX_FINISH;
        ENCX_FINISH: state_q <= ENCX_IDLE;
      endcase
    end
  end

  // =============================================
  // faults
  // =============================================
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      faultValid <= 1'b0;
      faultVector <= 8'h00;
      faultCode <= FAULT_NONE;
    end else begin
      faultValid <= (state_q == ENCX_CHECK) && (chkBus.verdict != ENCX_OK);
      if (state_q == ENCX_CHECK && chkBus.verdict == ENCX_GP) begin
        faultVector <= VEC_GP;
        faultCode <= GP_ERR_CODE;
      end else if (state_q == ENCX_CHECK && chkBus.verdict == ENCX_PF) begin
        faultVector <= VEC_PF;
        faultCode <= pageFaultCode;
      end
    end
  end

  // =============================================
  // save registers written at entry
  // =============================================
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      saveXcr_q <= '0;
      saveTf_q <= 1'b0;
      optin_q <= 1'b0;
      saveCfg_q <= '0;
      saveSsp_q <= ADDR_ZERO;
      saveA_q <= '0;
      saveB_q <= '0;
    end else if (entrySave) begin
      saveA_q <= segAIn;
      saveB_q <= segBIn;
      optin_q <= entryDebugOptin;
      if (osExtSaveEnable) begin
        saveXcr_q <= extFeatureIn;
      end
      if (!entryDebugOptin) begin
        saveTf_q <= trapFlagIn;
      end
      if (supportBranchTrack || supportShadowStack) begin
        saveCfg_q <= userFlowConfigIn;
      end
      if (supportShadowStack) begin
        saveSsp_q <= shadowStackPtrIn;
      end
    end
  end

  encx_state_restore u_restore (
    .clock(clock),
    .rst_b(rst_b),
    .load(restoreLoad),
    .savedA(saveA_q),
    .savedB(saveB_q),
    .segA(segA),
    .segB(segB)
  );

  // =============================================
  // architectural updates on commit
  // =============================================
  always_comb begin
    cfgRestored = saveCfg_q;
    if (flowProtectEnable && saveCfg_q[CFG_BRTRK_BIT]) begin
      cfgRestored[CFG_TRACKER_BIT] = 1'b1;
      cfgRestored[CFG_SUPPRESS_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      instrPtr <= ADDR_ZERO;
      countReg <= ADDR_ZERO;
      lastBranchFrom <= ADDR_ZERO;
      extFeatureEnableReg <= '0;
      userFlowConfig <= '0;
      shadowStackPtr <= ADDR_ZERO;
      prevShadowPtr <= ADDR_ZERO;
      prevShadowWrite <= 1'b0;
    end else begin
      prevShadowWrite <= 1'b0;
      if (restoreLoad) begin
        lastBranchFrom <= currentInstrPtr;
        instrPtr <= tgt_q;
        countReg <= asyncExitPointer;
        if (osExtSaveEnable) begin
          extFeatureEnableReg <= saveXcr_q;
        end
        if (capPrevShadow && userFlowConfigIn[CFG_SHSTK_BIT]) begin
          prevShadowPtr <= shadowStackPtrIn;
          prevShadowWrite <= 1'b1;
        end
        if (supportBranchTrack || supportShadowStack) begin
          userFlowConfig <= cfgRestored;
        end
        if (supportShadowStack) begin
          shadowStackPtr <= saveSsp_q;
        end
      end
    end
  end

  // =============================================
  // debug and monitoring suppression
  // =============================================
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      outsideBpSuppressed <= 1'b0;
      insideBpSuppressed <= 1'b0;
      monitorTrapSuppressed <= 1'b0;
      branchRecordSuppressed <= 1'b0;
      perfMonSuppressed <= 1'b0;
      anyThreadDemoted <= 1'b0;
      trapFlag <= 1'b0;
    end else if (entrySave) begin
      outsideBpSuppressed <= 1'b1;
      insideBpSuppressed <= !entryDebugOptin;
      monitorTrapSuppressed <= !entryDebugOptin;
      branchRecordSuppressed <= !entryDebugOptin;
      perfMonSuppressed <= !entryDebugOptin;
      anyThreadDemoted <= !entryDebugOptin;
      trapFlag <= entryDebugOptin ? trapFlagIn : 1'b0;
    end else if (restoreLoad) begin
      outsideBpSuppressed <= 1'b0;
      if (!optin_q) begin
        insideBpSuppressed <= 1'b0;
        monitorTrapSuppressed <= 1'b0;
        branchRecordSuppressed <= 1'b0;
        perfMonSuppressed <= 1'b0;
        anyThreadDemoted <= 1'b0;
        trapFlag <= saveTf_q;
      end
    end
  end

  // =============================================
  // pending events at end of instruction, final steps
  // =============================================
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pendSingleStep <= 1'b0;
      pendMonitorTrap <= 1'b0;
      inEnclaveFlag <= 1'b0;
      tcsState <= TCS_INACTIVE;
      flushLinear <= 1'b0;
      done <= 1'b0;
      nonEnclaveFetch <= 1'b0;
    end else begin
      pendSingleStep <= (state_q == ENCX_FINISH) && trapFlag;
      pendMonitorTrap <= (state_q == ENCX_FINISH) && monitorTrapCtl;
      flushLinear <= (state_q == ENCX_FINISH);
      done <= (state_q == ENCX_FINISH);
      if (entrySave) begin
        inEnclaveFlag <= 1'b1;
        tcsState <= TCS_ACTIVE;
        nonEnclaveFetch <= 1'b0;
      end else if (state_q == ENCX_COMMIT) begin
        inEnclaveFlag <= 1'b0;
        tcsState <= TCS_INACTIVE;
        nonEnclaveFetch <= 1'b1;
      end
    end
  end

  // =============================================
  // checks
  // =============================================
  property p_leaf_start;
    @(posedge clock) disable iff (!rst_b)
      (state_q == ENCX_IDLE && issueValid && leafSelector == LEAF_EXIT) |=> state_q == ENCX_CHECK;
  endproperty
  a_leaf_start: assert property (p_leaf_start) else $error("exit leaf not started");

  property p_ip_load;
    @(posedge clock) disable iff (!rst_b)
      restoreLoad |=> (instrPtr == $past(tgt_q)) && (countReg == $past(asyncExitPointer));
  endproperty
  a_ip_load: assert property (p_ip_load) else $error("target or exit pointer not loaded");

  property p_gp_outside;
    @(posedge clock) disable iff (!rst_b)
      (state_q == ENCX_CHECK && !inEnclaveFlag) |=> faultValid && faultVector == VEC_GP;
  endproperty
  a_gp_outside: assert property (p_gp_outside) else $error("no fault outside enclave");

  property p_no_change_on_fault;
    @(posedge clock) disable iff (!rst_b)
      (state_q == ENCX_CHECK && chkBus.verdict != ENCX_OK) |=>
        $stable(instrPtr) ##1 (inEnclaveFlag == $past(inEnclaveFlag, 2));
  endproperty
  a_no_change_on_fault: assert property (p_no_change_on_fault)
    else $error("state changed on fault");

  property p_xcr_restore;
    @(posedge clock) disable iff (!rst_b)
      (restoreLoad && osExtSaveEnable) |=> extFeatureEnableReg == $past(saveXcr_q);
  endproperty
  a_xcr_restore: assert property (p_xcr_restore) else $error("feature reg not restored");

  property p_bp_out;
    @(posedge clock) disable iff (!rst_b)
      restoreLoad |=> !outsideBpSuppressed;
  endproperty
  a_bp_out: assert property (p_bp_out) else $error("outside breakpoints still suppressed");

  property p_optout;
    @(posedge clock) disable iff (!rst_b)
      (restoreLoad && !optin_q) |=>
        !insideBpSuppressed && !perfMonSuppressed && trapFlag == $past(saveTf_q);
  endproperty
  a_optout: assert property (p_optout) else $error("opt-out restore incomplete");

  property p_single_step;
    @(posedge clock) disable iff (!rst_b)
      (restoreLoad && !optin_q && saveTf_q) |=> ##2 pendSingleStep && done;
  endproperty
  a_single_step: assert property (p_single_step) else $error("single-step not pended");

  property p_final;
    @(posedge clock) disable iff (!rst_b)
      restoreLoad |=> ##1 !inEnclaveFlag && tcsState == TCS_INACTIVE ##1 flushLinear;
  endproperty
  a_final: assert property (p_final) else $error("exit final steps missing");
endmodule

// ### hdl/encx_pkg.sv
// constants and types shared by the enclave exit sequencer
package encx_pkg;
  localparam int ADDR_W = 64;
  localparam int SEL_W = 16;
  localparam int LIM_W = 32;
  localparam int AR_W = 16;
  localparam int XCR_W = 64;
  localparam int CFG_W = 64;
  localparam logic [31:0] LEAF_EXIT = 32'h0000_0004;
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] GP_ERR_CODE = 16'h0000;
  localparam logic [7:0] VEC_GP = 8'h0D;
  localparam logic [7:0] VEC_PF = 8'h0E;
  localparam int CANON_BITS = 48;
  localparam int CAP_SHSTK_PREV_BIT = 6;
  localparam int CFG_SHSTK_BIT = 0;
  localparam int CFG_BRTRK_BIT = 2;
  localparam int CFG_SUPPRESS_BIT = 10;
  localparam int CFG_TRACKER_BIT = 11;
  localparam logic [1:0] TCS_INACTIVE = 2'h0;
  localparam logic [1:0] TCS_ACTIVE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 64'h0000_0000_0000_0000;
  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [ADDR_W-1:0] base;
    logic [LIM_W-1:0] limit;
    logic [AR_W-1:0] ar;
  } encx_seg_t;
  typedef enum logic [1:0] {
    ENCX_OK,
    ENCX_GP,
    ENCX_PF
  } encx_verdict_t;
endpackage

// ### hdl/encx_state_restore.sv
// segment pair holding restored on exit
module encx_state_restore
  import encx_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic load,
  input encx_seg_t savedA,
  input encx_seg_t savedB,
  output encx_seg_t segA,
  output encx_seg_t segB
);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      segA <= '0;
      segB <= '0;
    end else if (load) begin
      segA <= savedA;
      segB <= savedB;
    end
  end
endmodule

// ### hdl/encx_target_check.sv
// fault screening of the exit target and enclave mode
module encx_target_check
  import encx_pkg::*;
(
  encx_check_if.chk chk
);
  function automatic logic isCanonical(input logic [ADDR_W-1:0] a);
    isCanonical = (&a[ADDR_W-1:CANON_BITS-1]) | ~(|a[ADDR_W-1:CANON_BITS-1]);
  endfunction

  always_comb begin
    chk.mode64 = chk.longModeActive & chk.csLongBit;
    if (!chk.inEnclave) begin
      chk.verdict = ENCX_GP;
    end else if (chk.mode64 && !isCanonical(chk.target)) begin
      chk.verdict = ENCX_GP;
    end else if (!chk.mode64 && (chk.target > {32'h0000_0000, chk.csLimit})) begin
      chk.verdict = ENCX_GP;
    end else if (chk.pfPending) begin
      chk.verdict = ENCX_PF;
    end else begin
      chk.verdict = ENCX_OK;
    end
  end
endmodule

// ### testbench/testbench.sv
// self-checking bench for the enclave exit sequencer
module testbench;
  import encx_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // stimulus and observed signals
  logic clock = 1'b0;
  logic rst_b, issueValid, pageFaultIn, longModeActive, csLongBit, osExtSaveEnable;
  logic flowProtectEnable, capPrevShadow, supportBranchTrack, supportShadowStack;
  logic monitorTrapCtl, entrySave, entryDebugOptin, trapFlagIn;
  logic [31:0] leafSelector;
  logic [LIM_W-1:0] csLimit;
  logic [15:0] pageFaultCode;
  logic [ADDR_W-1:0] targetAddr, currentInstrPtr, asyncExitPointer, shadowStackPtrIn;
  logic [CFG_W-1:0] userFlowConfigIn;
  logic [XCR_W-1:0] extFeatureIn;
  encx_seg_t segAIn, segBIn, segA, segB;
  logic done, faultValid, trapFlag, inEnclaveFlag, prevShadowWrite, outsideBpSuppressed;
  logic insideBpSuppressed, monitorTrapSuppressed, branchRecordSuppressed, perfMonSuppressed;
  logic anyThreadDemoted, pendSingleStep, pendMonitorTrap, flushLinear, nonEnclaveFetch;
  logic [7:0] faultVector;
  logic [15:0] faultCode;
  logic [1:0] tcsState;
  logic [ADDR_W-1:0] instrPtr, countReg, lastBranchFrom, prevShadowPtr, shadowStackPtr;
  logic [XCR_W-1:0] extFeatureEnableReg;
  logic [CFG_W-1:0] userFlowConfig;
  int bad_count = 0;
  int n_checks = 0;

  always #2.5 clock = ~clock;

  encx_exit_sequencer uut (
    .clock, .rst_b, .issueValid, .leafSelector, .targetAddr, .currentInstrPtr,
    .pageFaultIn, .pageFaultCode, .longModeActive, .csLongBit, .csLimit, .osExtSaveEnable,
    .flowProtectEnable, .capPrevShadow, .supportBranchTrack, .supportShadowStack,
    .monitorTrapCtl, .asyncExitPointer, .shadowStackPtrIn, .userFlowConfigIn, .entrySave,
    .entryDebugOptin, .extFeatureIn, .trapFlagIn, .segAIn, .segBIn, .done, .faultValid,
    .faultVector, .faultCode, .instrPtr, .countReg, .lastBranchFrom, .segA, .segB,
    .extFeatureEnableReg, .trapFlag, .inEnclaveFlag, .tcsState, .prevShadowPtr,
    .prevShadowWrite, .userFlowConfig, .shadowStackPtr, .outsideBpSuppressed,
    .insideBpSuppressed, .monitorTrapSuppressed, .branchRecordSuppressed, .perfMonSuppressed,
    .anyThreadDemoted, .pendSingleStep, .pendMonitorTrap, .flushLinear, .nonEnclaveFetch
  );

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic step;
    @(posedge clock);
    #1;
  endtask

  // returns just after the edge where restores or a fault show
  task automatic issue(input logic [31:0] leaf, input logic [63:0] tgt);
    @(posedge clock);
    issueValid <= 1'b1;
    leafSelector <= leaf;
    targetAddr <= tgt;
    @(posedge clock);
    issueValid <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic enter(input logic optin, input logic tf);
    @(posedge clock);
    entrySave <= 1'b1;
    entryDebugOptin <= optin;
    trapFlagIn <= tf;
    @(posedge clock);
    entrySave <= 1'b0;
    step();
    chk(inEnclaveFlag, 1'b1);
  endtask

  task automatic expect_fault(input logic [7:0] vec, input logic [15:0] code,
      input logic inEncl, input logic [63:0] ip);
    chk({faultValid, faultVector, faultCode}, {1'b1, vec, code});
    chk(instrPtr, ip);
    repeat (2) step();
    chk(done, 1'b0);
    chk(inEnclaveFlag, inEncl);
  endtask

  task automatic gp_case(input logic lma, input logic csl, input logic pf,
      input logic [63:0] tgt);
    @(posedge clock);
    longModeActive <= lma;
    csLongBit <= csl;
    pageFaultIn <= pf;
    issue(LEAF_EXIT, tgt);
    expect_fault(VEC_GP, GP_ERR_CODE, 1'b1, ADDR_ZERO);
    pageFaultIn <= 1'b0;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_other_leaves;
    for (int l = 0; l < 6; l++) begin
      if (l != 4) begin
        issue(l, 64'h0000_0000_0040_1000);
        chk(faultValid, 1'b0);
        repeat (2) step();
        chk(done, 1'b0);
      end
    end
  endtask

  task automatic t_bad_targets;
    gp_case(1'b1, 1'b1, 1'b0, 64'h0000_8000_0000_0000);
    gp_case(1'b1, 1'b1, 1'b0, 64'hFFFF_7FFF_FFFF_FFFF);
    gp_case(1'b1, 1'b0, 1'b0, 64'h0000_0000_0001_0000);
    gp_case(1'b0, 1'b1, 1'b1, 64'h0000_0000_0001_0000);
  endtask

  task automatic t_page_fault;
    @(posedge clock);
    longModeActive <= 1'b1;
    csLongBit <= 1'b1;
    pageFaultIn <= 1'b1;
    issue(LEAF_EXIT, 64'h0000_0000_0040_1000);
    expect_fault(VEC_PF, pageFaultCode, 1'b1, ADDR_ZERO);
    pageFaultIn <= 1'b0;
  endtask

  task automatic t_exit_opt_out;
    logic [63:0] tgt;
    tgt = 64'hFFFF_8000_0000_0000;
    issue(LEAF_EXIT, tgt);
    chk(faultValid, 1'b0);
    chk(prevShadowWrite, 1'b1);
    chk({instrPtr, countReg}, {tgt, asyncExitPointer});
    chk(inEnclaveFlag, 1'b1);
    step();
    chk({inEnclaveFlag, tcsState, nonEnclaveFetch}, {1'b0, TCS_INACTIVE, 1'b1});
    step();
    chk({done, flushLinear}, 2'b11);
    chk({pendSingleStep, trapFlag}, 2'b11);
    chk(pendMonitorTrap, 1'b1);
    chk(lastBranchFrom, currentInstrPtr);
    chk(segA, segAIn);
    chk(segB, segBIn);
    chk(extFeatureEnableReg, extFeatureIn);
    chk(outsideBpSuppressed, 1'b0);
    chk({insideBpSuppressed, monitorTrapSuppressed, branchRecordSuppressed,
      perfMonSuppressed, anyThreadDemoted}, 5'h00);
    chk(prevShadowPtr, shadowStackPtrIn);
    chk(shadowStackPtr, shadowStackPtrIn);
    chk(userFlowConfig, 64'h0000_0000_0000_0805);
    step();
    chk({done, flushLinear, pendSingleStep}, 3'b000);
    issue(LEAF_EXIT, 64'h0000_0000_0040_1000);
    expect_fault(VEC_GP, GP_ERR_CODE, 1'b0, tgt);
  endtask

  task automatic t_exit_opt_in;
    @(posedge clock);
    {osExtSaveEnable, flowProtectEnable, capPrevShadow, monitorTrapCtl} <= 4'h0;
    {supportBranchTrack, supportShadowStack, longModeActive} <= 3'b000;
    extFeatureIn <= 64'h0000_0000_0000_0003;
    userFlowConfigIn <= 64'h0000_0000_0000_0004;
    enter(1'b1, 1'b0);
    issue(LEAF_EXIT, 64'h0000_0000_0000_FFFF);
    chk(instrPtr, 64'h0000_0000_0000_FFFF);
    chk(prevShadowWrite, 1'b0);
    repeat (2) step();
    chk({pendSingleStep, trapFlag, insideBpSuppressed}, 3'b000);
    chk({done, pendMonitorTrap, outsideBpSuppressed}, 3'b100);
    chk(extFeatureEnableReg, 64'h0000_0000_0000_0007);
    chk(userFlowConfig, 64'h0000_0000_0000_0805);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    rst_b = 1'b0;
    {issueValid, pageFaultIn, entrySave, entryDebugOptin, trapFlagIn} = 5'h00;
    {longModeActive, csLongBit, osExtSaveEnable, flowProtectEnable} = 4'hF;
    {capPrevShadow, supportBranchTrack, supportShadowStack, monitorTrapCtl} = 4'hF;
    leafSelector = 32'h0000_0000;
    targetAddr = ADDR_ZERO;
    csLimit = 32'h0000_FFFF;
    pageFaultCode = 16'h0006;
    currentInstrPtr = 64'h0000_0000_1000_0010;
    asyncExitPointer = 64'h0000_0000_0040_2000;
    shadowStackPtrIn = 64'h0000_7FFF_0000_1000;
    userFlowConfigIn = 64'h0000_0000_0000_0405;
    extFeatureIn = 64'h0000_0000_0000_0007;
    segAIn = '{16'h0023, 64'h0000_0000_7000_0000, 32'h0000_FFFF, 16'h00F3};
    segBIn = '{16'h002B, 64'h0000_0000_7100_0000, 32'h000F_FFFF, 16'h00F3};
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    enter(1'b0, 1'b1);
    chk({outsideBpSuppressed, insideBpSuppressed, perfMonSuppressed}, 3'b111);
    t_other_leaves();
    t_bad_targets();
    t_page_fault();
    t_exit_opt_out();
    t_exit_opt_in();
    wrap_up();
  end

  initial begin
    #20000;
    bad_count++;
    wrap_up();
  end
endmodule
